// [motion_map.svh]
// Register map, field positions and codes of the motion-control register
//
// Function
// - Motor enable cleared turns all bridge switches off; set follows operating mode.
// - Third-pin function 10b makes hold select read-only, mirroring multi-function pin.
// - With stall flag and auto-hold both set, hold clear requests are ignored.
// - Resolution codes: 001 eighth, 010 mini, 011 half, 100 full, others sixteenth.
// - Alternative resolution active when pin stepping, function 01b and pin high.
// - Primary resolution active with pin stepping unless function 01b and pin high.
// - Step pin rising edge increments counter when direction 0, decrements when 1.
// - Six-bit counter encodes electrical angle, 000000 zero, 100000 180 degrees.
// - Counter value selects current profiles for both motor phases.
// - With pin stepping routed, counter field is read-only to writes.
// - Without pin stepping, written counter value applies at next PWM period start.
// - Without pin stepping, step pin is ignored; counter changes only by writes.
`ifndef MOTION_MAP_SVH
`define MOTION_MAP_SVH

// ****************************************
// Address and reset
// ****************************************
`define MOTOR_CONTROL_ONE_OFFSET 8'h05
`define MOTOR_CONTROL_ONE_RESET 16'h0000

// ****************************************
// Field positions
// ****************************************
`define ME_BIT 15
`define HOLD_BIT 14
`define ALT_RES_HI 13
`define ALT_RES_LO 11
`define PRIM_RES_HI 10
`define PRIM_RES_LO 8
`define DIR_BIT 7
`define POS_HI 6
`define POS_LO 1

// ****************************************
// Codes and counts
// ****************************************
`define THIRD_FN_SMODE 2'h1
`define THIRD_FN_HOLD 2'h2
`define RES_EIGHTH 3'h1
`define RES_MINI 3'h2
`define RES_HALF 3'h3
`define RES_FULL 3'h4
`define RES_ZERO 3'h0
`define POS_ZERO 6'h00
`define POS_ONE 6'h01
`define POS_MAX 6'h3f
`define POS_QUARTER_TURN 6'h10

`endif

// [motion_pkg.sv]
// Types shared by the motion-control logic
package motion_pkg;
	typedef enum logic [4:0] {
		STEP_SIXTEENTH = 5'h01,
		STEP_EIGHTH = 5'h02,
		STEP_MINI = 5'h04,
		STEP_HALF = 5'h08,
		STEP_FULL = 5'h10
	} step_mode_t;
endpackage

// [motion_if.sv]
// Carrier between the register logic and the resolution/profile decoder
`timescale 1ns/10ps
interface motion_if;
	import motion_pkg::*;
	logic [2:0] primary_res;
	logic [2:0] alt_res;
	logic use_alt;
	logic [5:0] position;
	step_mode_t step_mode;
	logic [5:0] profile_a;
	logic [5:0] profile_b;
	modport ctrl (
		output primary_res, alt_res, use_alt, position,
		input step_mode, profile_a, profile_b
	);
	modport decode (
		input primary_res, alt_res, use_alt, position,
		output step_mode, profile_a, profile_b
	);
endinterface

// [step_profile_decode.sv]
// Step resolution decode and phase profile selection
`timescale 1ns/10ps
`include "motion_map.svh"
module step_profile_decode (
	// Clock and reset, for checks only
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Decoder side of the carrier
	motion_if.decode bus
);
	import motion_pkg::*;

	// ****************************************
	// Resolution decode
	// ****************************************
	wire logic [2:0] active_res;
	assign active_res = bus.use_alt ? bus.alt_res : bus.primary_res;

	always_comb begin
		case (active_res)
			`RES_EIGHTH: bus.step_mode = STEP_EIGHTH;
			`RES_MINI: bus.step_mode = STEP_MINI;
			`RES_HALF: bus.step_mode = STEP_HALF;
			`RES_FULL: bus.step_mode = STEP_FULL;
			default: bus.step_mode = STEP_SIXTEENTH;
		endcase
	end

	// ****************************************
	// Profile selection
	// ****************************************
	// Phase B leads phase A by a quarter of the electrical period
	assign bus.profile_a = bus.position;
	assign bus.profile_b = bus.position + `POS_QUARTER_TURN;

	// ****************************************
	// Checks
	// ****************************************
	property p_decode_codes;
		@(posedge i_clk) disable iff (i_sys_rst)
		(active_res == `RES_FULL |-> bus.step_mode == STEP_FULL) and
		(active_res == `RES_EIGHTH |-> bus.step_mode == STEP_EIGHTH) and
		(active_res > `RES_FULL || active_res == `RES_ZERO |-> bus.step_mode == STEP_SIXTEENTH);
	endproperty
	a_decode_codes: assert property (p_decode_codes) else $error("resolution decode wrong");

	property p_profile_offset;
		@(posedge i_clk) disable iff (i_sys_rst)
		bus.profile_b == 6'(bus.profile_a + `POS_QUARTER_TURN) && bus.profile_a == bus.position;
	endproperty
	a_profile_offset: assert property (p_profile_offset) else $error("profile select wrong");
endmodule

// [stepper_motion_control_register.sv]
// Motion-control register of the stepper driver with pin routing
`timescale 1ns/10ps
`include "motion_map.svh"
module stepper_motion_control_register (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Register access
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	// Routing settings from global configuration
	input wire logic i_pin_stepping_routing,
	input wire logic i_rotation_pin_routing,
	input wire logic [1:0] i_third_pin_function,
	// Control pins
	input wire logic i_step_clock_pin,
	input wire logic i_rotation_pin,
	input wire logic i_multi_function_pin,
	// Status and timing
	input wire logic i_stall_flag,
	input wire logic i_auto_hold_on_stall,
	input wire logic i_pwm_period_start,
	// Motor side
	output logic o_bridge_enable,
	output logic o_hold_mode,
	output logic o_direction,
	output motion_pkg::step_mode_t o_step_mode,
	output logic [5:0] o_angular_position,
	output logic [5:0] o_profile_a,
	output logic [5:0] o_profile_b
);
	import motion_pkg::*;

	motion_if mif ();

	logic motor_enable_reg;
	logic hold_select_reg;
	logic [2:0] alt_res_reg;
	logic [2:0] prim_res_reg;
	logic dir_reg;
	logic [5:0] pos_reg;
	logic [5:0] pend_pos_reg;
	logic pend_valid_reg;
	logic step_pin_prev_reg;
	logic [15:0] rdata_reg;
	logic hold_out_reg;
	logic dir_out_reg;
	step_mode_t step_mode_reg;
	logic [5:0] profile_a_reg;
	logic [5:0] profile_b_reg;

	// ****************************************
	// Write decode
	// ****************************************
	wire logic addr_hit;
	wire logic wr_me;
	wire logic wr_hold;
	wire logic wr_dir;
	wire logic [2:0] wr_alt;
	wire logic [2:0] wr_prim;
	wire logic [5:0] wr_pos;
	assign addr_hit = i_reg_wr && (i_reg_addr == `MOTOR_CONTROL_ONE_OFFSET);
	assign wr_me = i_reg_wdata[`ME_BIT];
	assign wr_hold = i_reg_wdata[`HOLD_BIT];
	assign wr_dir = i_reg_wdata[`DIR_BIT];
	assign wr_alt = i_reg_wdata[`ALT_RES_HI:`ALT_RES_LO];
	assign wr_prim = i_reg_wdata[`PRIM_RES_HI:`PRIM_RES_LO];
	assign wr_pos = i_reg_wdata[`POS_HI:`POS_LO];

	// ****************************************
	// Hold select
	// ****************************************
	wire logic hold_pin_mode;
	wire logic hold_clear_blocked;
	wire logic hold_select_next;
	wire logic hold_effective;
	assign hold_pin_mode = (i_third_pin_function == `THIRD_FN_HOLD);
	assign hold_clear_blocked = i_stall_flag && i_auto_hold_on_stall;
	// Outside hold pin mode setting hold is always allowed; only a clear is blocked, by the stall flag with auto-hold set
	assign hold_select_next = (addr_hit && !hold_pin_mode && (wr_hold || !hold_clear_blocked))
		? wr_hold : hold_select_reg;
	assign hold_effective = hold_pin_mode ? i_multi_function_pin : hold_select_reg;

	// ****************************************
	// Direction
	// ****************************************
	wire logic dir_next;
	wire logic dir_effective;
	assign dir_next = (addr_hit && !i_rotation_pin_routing) ? wr_dir : dir_reg;
	assign dir_effective = i_rotation_pin_routing ? i_rotation_pin : dir_reg;

	// ****************************************
	// Angular position counter
	// ****************************************
	wire logic step_rise;
	wire logic [5:0] pos_step;
	wire logic pend_take;
	wire logic pend_apply;
	wire logic [5:0] pos_next;
	wire logic pend_valid_next;
	wire logic [5:0] pend_pos_next;
	assign step_rise = i_pin_stepping_routing && i_step_clock_pin && !step_pin_prev_reg;
	// Six-bit arithmetic wraps on its own, keeping rotation continuous
	assign pos_step = dir_effective ? pos_reg - `POS_ONE : pos_reg + `POS_ONE;
	assign pend_take = addr_hit && !i_pin_stepping_routing;
	assign pend_apply = i_pwm_period_start && pend_valid_reg && !i_pin_stepping_routing;
	assign pos_next = step_rise ? pos_step : (pend_apply ? pend_pos_reg : pos_reg);
	// A new write in the applying cycle stays pending for the following period
	assign pend_valid_next = pend_take ? 1'b1
		: ((pend_apply || i_pin_stepping_routing) ? 1'b0 : pend_valid_reg);
	assign pend_pos_next = pend_take ? wr_pos : pend_pos_reg;

	// ****************************************
	// Carrier and read data
	// ****************************************
	wire logic [15:0] rdata_next;
	assign mif.primary_res = prim_res_reg;
	assign mif.alt_res = alt_res_reg;
	assign mif.use_alt = i_pin_stepping_routing && (i_third_pin_function == `THIRD_FN_SMODE)
		&& i_multi_function_pin;
	assign mif.position = pos_reg;
	// Parity slot is framing, not stored here, so it reads zero
	assign rdata_next = {motor_enable_reg, hold_effective, alt_res_reg, prim_res_reg,
		dir_effective, pos_reg, 1'b0};

	step_profile_decode u_decode (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.bus(mif.decode)
	);

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			motor_enable_reg <= 1'b0;
			hold_select_reg <= 1'b0;
			alt_res_reg <= `RES_ZERO;
			prim_res_reg <= `RES_ZERO;
			dir_reg <= 1'b0;
			pos_reg <= `POS_ZERO;
			pend_pos_reg <= `POS_ZERO;
			pend_valid_reg <= 1'b0;
		end else begin
			if (addr_hit) begin
				motor_enable_reg <= wr_me;
				alt_res_reg <= wr_alt;
				prim_res_reg <= wr_prim;
			end
			hold_select_reg <= hold_select_next;
			dir_reg <= dir_next;
			pos_reg <= pos_next;
			pend_pos_reg <= pend_pos_next;
			pend_valid_reg <= pend_valid_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			step_pin_prev_reg <= 1'b0;
			rdata_reg <= `MOTOR_CONTROL_ONE_RESET;
			hold_out_reg <= 1'b0;
			dir_out_reg <= 1'b0;
			step_mode_reg <= STEP_SIXTEENTH;
			profile_a_reg <= `POS_ZERO;
			profile_b_reg <= `POS_QUARTER_TURN;
		end else begin
			step_pin_prev_reg <= i_step_clock_pin;
			rdata_reg <= rdata_next;
			hold_out_reg <= hold_effective;
			dir_out_reg <= dir_effective;
			step_mode_reg <= mif.step_mode;
			profile_a_reg <= mif.profile_a;
			profile_b_reg <= mif.profile_b;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Bridge switches all off while disabled, outputs float
	assign o_bridge_enable = motor_enable_reg;
	assign o_hold_mode = hold_out_reg;
	assign o_direction = dir_out_reg;
	assign o_step_mode = step_mode_reg;
	assign o_angular_position = pos_reg;
	assign o_profile_a = profile_a_reg;
	assign o_profile_b = profile_b_reg;
	assign o_reg_rdata = rdata_reg;

	// ****************************************
	// Checks
	// ****************************************
	property p_enable_write;
		@(posedge i_clk) disable iff (i_sys_rst)
		addr_hit |=> o_bridge_enable == $past(wr_me);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not taken");

	property p_hold_mirror;
		@(posedge i_clk) disable iff (i_sys_rst)
		hold_pin_mode |=> o_reg_rdata[`HOLD_BIT] == $past(i_multi_function_pin) &&
			o_hold_mode == $past(i_multi_function_pin);
	endproperty
	a_hold_mirror: assert property (p_hold_mirror) else $error("hold not mirrored");

	property p_hold_clear_blocked;
		@(posedge i_clk) disable iff (i_sys_rst)
		addr_hit && !wr_hold && hold_clear_blocked && hold_select_reg |=> hold_select_reg;
	endproperty
	a_hold_clear_blocked: assert property (p_hold_clear_blocked) else $error("hold cleared");

	property p_step_up;
		@(posedge i_clk) disable iff (i_sys_rst)
		step_rise && !dir_effective |=> pos_reg == 6'($past(pos_reg) + `POS_ONE);
	endproperty
	a_step_up: assert property (p_step_up) else $error("increment wrong");

	property p_step_wrap_down;
		@(posedge i_clk) disable iff (i_sys_rst)
		step_rise && dir_effective && pos_reg == `POS_ZERO |=> pos_reg == `POS_MAX;
	endproperty
	a_step_wrap_down: assert property (p_step_wrap_down) else $error("wrap wrong");

	property p_dir_pin;
		@(posedge i_clk) disable iff (i_sys_rst)
		i_rotation_pin_routing |=> o_reg_rdata[`DIR_BIT] == $past(i_rotation_pin) &&
			$stable(dir_reg);
	endproperty
	a_dir_pin: assert property (p_dir_pin) else $error("direction not from pin");

	property p_pos_readonly;
		@(posedge i_clk) disable iff (i_sys_rst)
		i_pin_stepping_routing && !step_rise |=> $stable(pos_reg);
	endproperty
	a_pos_readonly: assert property (p_pos_readonly) else $error("counter written");

	property p_step_pin_ignored;
		@(posedge i_clk) disable iff (i_sys_rst)
		!i_pin_stepping_routing && !pend_apply |=> $stable(pos_reg);
	endproperty
	a_step_pin_ignored: assert property (p_step_pin_ignored) else $error("step not ignored");

	sequence s_write_then_period;
		pend_take ##1 pend_apply;
	endsequence

	property p_deferred_write;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_write_then_period |=> pos_reg == $past(wr_pos, 2) &&
			o_reg_rdata[`POS_HI:`POS_LO] == $past(pos_reg);
	endproperty
	a_deferred_write: assert property (p_deferred_write) else $error("write not applied");

	property p_reset_zero;
		@(posedge i_clk) disable iff (i_sys_rst)
		$fell(i_sys_rst) |-> !o_bridge_enable && pos_reg == `POS_ZERO && !hold_select_reg
			&& o_step_mode == STEP_SIXTEENTH;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");
endmodule

// [host_pins.sv]
// Host-side model of the step clock pin and the PWM period start pulse
`timescale 1ns/10ps
module host_pins (
	// Clock
	input wire logic i_clk,
	// Requests from the bench
	input wire logic i_start,
	input wire logic [6:0] i_n_steps,
	input wire logic i_pwm_en,
	// Pins toward the block and busy flag toward the bench
	output logic o_step_clock_pin,
	output logic o_busy,
	output logic o_pwm_period_start
);
	logic [6:0] left_reg;
	logic [2:0] pwm_cnt_reg;
	assign o_busy = (left_reg != 7'h00);
	// Pin low at least one cycle between rising edges
	always @(posedge i_clk) begin
		if (i_start) begin
			left_reg <= i_n_steps;
			o_step_clock_pin <= 1'b0;
		end else if (o_busy) begin
			o_step_clock_pin <= ~o_step_clock_pin;
			if (o_step_clock_pin)
				left_reg <= left_reg - 7'h01;
		end else begin
			o_step_clock_pin <= 1'b0;
		end
	end
	// One-cycle pulse every eighth cycle, short period keeps runs brief
	always @(posedge i_clk) begin
		pwm_cnt_reg <= pwm_cnt_reg + 3'h1;
		o_pwm_period_start <= i_pwm_en && (pwm_cnt_reg == 3'h7);
	end
	initial begin
		left_reg = 7'h00;
		pwm_cnt_reg = 3'h0;
		o_step_clock_pin = 1'b0;
		o_pwm_period_start = 1'b0;
	end
endmodule

// [stepper_motion_control_register_tb_top.sv]
// Self-checking bench of the motion-control register
`timescale 1ns/10ps
module stepper_motion_control_register_tb_top;
	import motion_pkg::*;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0;
	logic [7:0] i_reg_addr = 8'h05;
	logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
	logic i_pin_stepping_routing = 1'b0, i_rotation_pin_routing = 1'b0;
	logic [1:0] i_third_pin_function = 2'h0;
	logic i_rotation_pin = 1'b0, i_multi_function_pin = 1'b0;
	logic i_stall_flag = 1'b0, i_auto_hold_on_stall = 1'b0;
	logic step_pin, pwm_start, busy, start = 1'b0, pwm_en = 1'b0;
	logic [6:0] n_steps = 7'h00;
	logic o_bridge_enable, o_hold_mode, o_direction;
	step_mode_t o_step_mode;
	logic [5:0] o_angular_position, o_profile_a, o_profile_b;
	int n_fail = 0, compares = 0, cycles = 0;
	stepper_motion_control_register dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_pin_stepping_routing(i_pin_stepping_routing),
		.i_rotation_pin_routing(i_rotation_pin_routing),
		.i_third_pin_function(i_third_pin_function), .i_step_clock_pin(step_pin),
		.i_rotation_pin(i_rotation_pin), .i_multi_function_pin(i_multi_function_pin),
		.i_stall_flag(i_stall_flag), .i_auto_hold_on_stall(i_auto_hold_on_stall),
		.i_pwm_period_start(pwm_start), .o_bridge_enable(o_bridge_enable),
		.o_hold_mode(o_hold_mode), .o_direction(o_direction), .o_step_mode(o_step_mode),
		.o_angular_position(o_angular_position), .o_profile_a(o_profile_a),
		.o_profile_b(o_profile_b));
	host_pins partner (.i_clk(i_clk), .i_start(start), .i_n_steps(n_steps),
		.i_pwm_en(pwm_en), .o_step_clock_pin(step_pin), .o_busy(busy),
		.o_pwm_period_start(pwm_start));
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
		settle();
	endtask
	task automatic steps(input logic [6:0] n);
		@(posedge i_clk);
		start <= 1'b1;
		n_steps <= n;
		@(posedge i_clk);
		start <= 1'b0;
		@(posedge i_clk);
		for (int k = 0; k < 400 && busy === 1'b1; k++)
			@(posedge i_clk);
		settle();
	endtask
	function automatic step_mode_t mode_of(input logic [2:0] c);
		case (c)
			3'h1: return STEP_EIGHTH;
			3'h2: return STEP_MINI;
			3'h3: return STEP_HALF;
			3'h4: return STEP_FULL;
			default: return STEP_SIXTEENTH;
		endcase
	endfunction
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk("rdata", 16'h0000, o_reg_rdata);
		chk("mode", 16'h0001, 16'(o_step_mode));
		chk("outs", 16'h0010, 16'({o_bridge_enable, o_hold_mode, o_direction, o_profile_b}));
		$display("test reset done");
	endtask
	task automatic t_enable();
		wr(8'h05, 16'h8000);
		chk("enable", 16'h8001, {o_reg_rdata[15], 15'(o_bridge_enable)});
		wr(8'h06, 16'h0000);
		chk("unmapped", 16'h0001, 16'(o_bridge_enable));
		wr(8'h05, 16'h0000);
		chk("disable", 16'h0000, 16'(o_bridge_enable));
		$display("test enable done");
	endtask
	task automatic t_resolution();
		i_pin_stepping_routing <= 1'b1;
		i_third_pin_function <= 2'h1;
		for (int c = 0; c < 8; c++) begin
			i_multi_function_pin <= 1'b1;
			wr(8'h05, {2'b00, 3'(c), 3'(7 - c), 8'h00});
			chk("alt", 16'(mode_of(3'(c))), 16'(o_step_mode));
			i_multi_function_pin <= 1'b0;
			settle();
			chk("prim", 16'(mode_of(3'(7 - c))), 16'(o_step_mode));
		end
		i_third_pin_function <= 2'h0;
		i_multi_function_pin <= 1'b1;
		wr(8'h05, 16'h0c00);
		chk("prim_off", 16'(STEP_FULL), 16'(o_step_mode));
		$display("test resolution done");
	endtask
	task automatic t_hold();
		i_third_pin_function <= 2'h2;
		wr(8'h05, 16'h0000);
		chk("mirror_hi", 16'h8001, {o_reg_rdata[14], 14'h0000, o_hold_mode});
		i_multi_function_pin <= 1'b0;
		wr(8'h05, 16'h4000);
		chk("mirror_lo", 16'h0000, {o_reg_rdata[14], 14'h0000, o_hold_mode});
		i_third_pin_function <= 2'h0;
		i_stall_flag <= 1'b1;
		i_auto_hold_on_stall <= 1'b1;
		wr(8'h05, 16'h4000);
		wr(8'h05, 16'h0000);
		chk("stall_block", 16'h0001, 16'(o_hold_mode));
		i_stall_flag <= 1'b0;
		wr(8'h05, 16'h0000);
		chk("hold_clear", 16'h0000, 16'(o_hold_mode));
		i_auto_hold_on_stall <= 1'b0;
		$display("test hold done");
	endtask
	task automatic t_spi_position();
		i_pin_stepping_routing <= 1'b0;
		wr(8'h05, 16'h000a);
		steps(7'd3);
		chk("pending", 16'h0000, 16'({o_reg_rdata[6:1], o_angular_position}));
		pwm_en <= 1'b1;
		repeat (12) @(posedge i_clk);
		pwm_en <= 1'b0;
		settle();
		chk("applied", 16'h0005, 16'(o_reg_rdata[6:1]));
		chk("profiles", 16'h0515, {2'b00, o_profile_a, 2'b00, o_profile_b});
		$display("test spi position done");
	endtask
	task automatic t_pin_stepping();
		i_pin_stepping_routing <= 1'b1;
		wr(8'h05, 16'h0000);
		steps(7'd3);
		chk("up", 16'h0008, 16'(o_angular_position));
		wr(8'h05, 16'h0080);
		steps(7'd10);
		chk("wrap", 16'h003e, 16'(o_angular_position));
		chk("ro_pos", 16'h00fc, {8'h00, o_reg_rdata[7:0]});
		i_rotation_pin_routing <= 1'b1;
		wr(8'h05, 16'h0080);
		chk("dir_pin", 16'h0000, 16'({o_reg_rdata[7], o_direction}));
		// Stored direction is 1 here, so counting up proves the pin wins
		steps(7'd2);
		chk("pin_up_wrap", 16'h0000, 16'(o_angular_position));
		i_rotation_pin <= 1'b1;
		steps(7'd2);
		chk("dir_down", 16'h003e, 16'(o_angular_position));
		chk("dir_hi", 16'h0003, 16'({o_reg_rdata[7], o_direction}));
		$display("test pin stepping done");
	endtask
	// ****************************************
	// Closing and timeout
	// ****************************************
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		settle();
		t_reset();
		t_enable();
		t_resolution();
		t_hold();
		t_spi_position();
		t_pin_stepping();
		summarize();
	end
endmodule
